//--- rtl/qr_timing_pkg.sv
/*
  Constants for the quasi-resonant switch timing sequencer: intervals,
  counts at the 50 MHz clock, limit-scale codes and sequencer states.
  Assumes a 50 MHz core clock.
*/
package qr_timing_pkg;
  localparam int  CLK_HZ           = 50_000_000;
  localparam int  BLANK_NS         = 250;
  localparam int  BOTTOM_MASK_NS   = 600;
  localparam int  TIMEOUT1_US      = 15;
  localparam int  TIMEOUT2_US      = 5;
  localparam int  OVP_FILTER_US    = 150;
  localparam int  CLAMP_DELAY_NS   = 600;
  localparam int  SS_STAGE1_MS     = 1;
  localparam int  SS_STAGE2_MS     = 4;
  localparam int  OVERLOAD_MS      = 128;
  // least times round up
  localparam int  BLANK_CYC        = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int  BOTTOM_MASK_CYC  = (BOTTOM_MASK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int  CLAMP_DELAY_CYC  = (CLAMP_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int  TIMEOUT1_CYC     = TIMEOUT1_US * (CLK_HZ / 1_000_000);
  localparam int  TIMEOUT2_CYC     = TIMEOUT2_US * (CLK_HZ / 1_000_000);
  localparam int  OVP_FILTER_CYC   = OVP_FILTER_US * (CLK_HZ / 1_000_000);
  localparam int  SS_STAGE1_CYC    = SS_STAGE1_MS * (CLK_HZ / 1000);
  localparam int  SS_STAGE2_CYC    = SS_STAGE2_MS * (CLK_HZ / 1000);
  localparam int  OVERLOAD_CYC     = OVERLOAD_MS * (CLK_HZ / 1000);
  localparam int  CNT_W            = 24;
  // current limit in percent of normal, 8 bits
  localparam logic [7:0] LIMIT_PCT_SS1    = 8'h19;
  localparam logic [7:0] LIMIT_PCT_SS2    = 8'h32;
  localparam logic [7:0] LIMIT_PCT_NORMAL = 8'h64;
  localparam logic [7:0] HIGH_LINE_PCT    = 8'h46;
  typedef enum logic [1:0] {
    SEQ_STOPPED = 2'b00,
    SEQ_OFF     = 2'b01,
    SEQ_ON      = 2'b10
  } seq_state_e;
endpackage : qr_timing_pkg

//--- rtl/input_sync.sv
/*
  Two flip-flop synchroniser for a bus of comparator levels.
  Assumes inputs are asynchronous to clk_in.
*/
`timescale 1ns/1ps
module input_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  // first stage feeds only the second
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : input_sync

//--- rtl/clamp_delay.sv
/*
  Clamp-drive output: a delayed copy of the gate drive, open drain.
  Assumes gate_in is synchronous to clk_in.
*/
`timescale 1ns/1ps
module clamp_delay
  import qr_timing_pkg::*;
#(
  parameter int DELAY_CYC = CLAMP_DELAY_CYC
) (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic gate_in,
  input  wire logic soft_start_in,
  output logic      clamp_oe_out,
  output logic      clamp_drive_out
);
  logic [DELAY_CYC-1:0] line;
  logic                 delayed;
  logic                 settling;
  // shift line; all ones means output released
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      line <= '0;
    end else begin
      line <= {line[DELAY_CYC-2:0], gate_in};
    end
  end
  assign delayed  = line[DELAY_CYC-1];
  // any disagreement inside the line means a transition is still in flight
  assign settling = (line != {DELAY_CYC{1'b0}}) && (line != {DELAY_CYC{1'b1}});
  // registered pull-down enable; soft start forces release
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clamp_oe_out <= 1'b1;
    end else if (soft_start_in) begin
      clamp_oe_out <= 1'b0; // RULE_16
    end else begin
      clamp_oe_out <= settling | ~delayed; // RULE_14 RULE_15
    end
  end
  assign clamp_drive_out = 1'b0;
  AST_SS_HIZ: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_16
    soft_start_in |=> !clamp_oe_out) else $error("clamp driven in soft start");
  AST_DELAY: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_15
    (!soft_start_in && $rose(gate_in)) ##1 !soft_start_in |=> clamp_oe_out)
    else $error("clamp released too early");
endmodule : clamp_delay

//--- rtl/qr_switch_timing.sv
/*
  Quasi-resonant flyback timing and protection sequencer: gate timing,
  blanking, bottom detect with mask and timeouts, soft start, overload,
  overvoltage filter and latches. Comparator inputs are asynchronous
  levels from analogue blocks; resetn_in is the supply power-on reset.
*/
`timescale 1ns/1ps
// Behaviour
// RULE_01 - ignore over-current for 250 ns after every gate rise
// RULE_02 - high-line flag scales current limit to 70 percent
// RULE_03 - bottom-detect comparator turns the gate on
// RULE_04 - bottom detect masked for a while after each gate edge
// RULE_05 - sense never above 200 mV for 15 us forces gate on
// RULE_06 - after a bottom, next bottom missing 5 us forces gate on
// RULE_07 - second timeout armed only after first bottom seen
// RULE_08 - undervoltage or brown-out restarts soft start
// RULE_09 - soft start limit 25 percent to 1 ms, 50 to 4 ms, then normal
// RULE_10 - feedback above upper level 128 ms declares overload, gate low
// RULE_11 - feedback below lower level clears overload timer
// RULE_12 - latch clears only when supply drops below release level
// RULE_13 - aux overvoltage latches after 150 us, shorter resets filter
// RULE_14 - clamp drive is delayed gate copy, open drain
// RULE_15 - clamp drive low during delay after each transition
// RULE_16 - clamp output released during soft start
// RULE_17 - over-temperature stops switching, auto resumes
// RULE_18 - brown-out and undervoltage recover automatically
// RULE_19 - overload, supply overvoltage latch or auto per variant
// RULE_20 - start only with supply good, line normal, no protection
// RULE_21 - inputs synchronised, intervals counted in clock cycles
module qr_switch_timing
  import qr_timing_pkg::*;
#(
  parameter bit OVERLOAD_LATCH = 1'b0,
  parameter bit SUPPLY_OVP_LATCH = 1'b1,
  parameter int OVERLOAD_CYCLES = OVERLOAD_CYC,
  parameter int OVP_CYCLES = OVP_FILTER_CYC,
  parameter int SS1_CYCLES = SS_STAGE1_CYC,
  parameter int SS2_CYCLES = SS_STAGE2_CYC,
  parameter int TOUT1_CYCLES = TIMEOUT1_CYC,
  parameter int TOUT2_CYCLES = TIMEOUT2_CYC
) (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       overcurrent_in,
  input  wire logic       high_line_in,
  input  wire logic       bottom_detect_in,
  input  wire logic       above_timeout_level_in,
  input  wire logic       fb_above_upper_in,
  input  wire logic       fb_below_lower_in,
  input  wire logic       line_normal_in,
  input  wire logic       supply_start_in,
  input  wire logic       supply_undervoltage_in,
  input  wire logic       supply_latch_release_in,
  input  wire logic       supply_overvoltage_in,
  input  wire logic       aux_overvoltage_in,
  input  wire logic       thermal_shutdown_in,
  output logic            gate_out,
  output logic [7:0]      limit_pct_out,
  output logic            soft_start_out,
  output logic            overload_out,
  output logic            latched_out,
  output logic            clamp_oe_out,
  output logic            clamp_drive_out
);
  localparam int NIN = 13;
  logic [NIN-1:0]   raw;
  logic [NIN-1:0]   syn;
  logic             s_oc, s_hl, s_bot, s_abv, s_fbu, s_fbl, s_line;
  logic             s_start, s_uv, s_rel, s_vov, s_aov, s_tsd;
  seq_state_e       state;
  seq_state_e       next_state;
  logic [CNT_W-1:0] blank_cnt, mask_cnt, tout1_cnt, tout2_cnt;
  logic [CNT_W-1:0] ss_cnt, ol_cnt, aovp_cnt, vovp_cnt;
  logic             bottom_seen, below_seen, ss_done, running;
  logic             ol_latch, aov_latch, vov_latch, vov_auto;
  logic             ovp_now, aovp_trip, vovp_trip, ol_trip, protect;
  logic             turn_on, turn_off, blanked, masked;
  logic [7:0]       ss_pct;

  // saturating increment used by every interval counter
  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c);
    bump = (c == {CNT_W{1'b1}}) ? c : c + 1'b1;
  endfunction : bump

  // every comparator level crosses into the clock domain here
  assign raw = {overcurrent_in, high_line_in, bottom_detect_in, above_timeout_level_in,
                fb_above_upper_in, fb_below_lower_in, line_normal_in, supply_start_in,
                supply_undervoltage_in, supply_latch_release_in, supply_overvoltage_in,
                aux_overvoltage_in, thermal_shutdown_in};
  input_sync #(.WIDTH(NIN)) u_sync ( // RULE_21
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .async_in  (raw),
    .sync_out  (syn)
  );
  assign {s_oc, s_hl, s_bot, s_abv, s_fbu, s_fbl, s_line, s_start,
          s_uv, s_rel, s_vov, s_aov, s_tsd} = syn;

  // protection summary; brown-out, undervoltage and thermal are not latched
  assign protect = ol_latch | ol_trip | aov_latch | vov_latch | vov_auto | s_tsd | s_uv | ~s_line; // RULE_17 RULE_18
  assign running = (state != SEQ_STOPPED);

  // blanking window and bottom-detect mask counters
  assign blanked = (blank_cnt < BLANK_CYC[CNT_W-1:0]); // RULE_01
  assign masked  = (mask_cnt < BOTTOM_MASK_CYC[CNT_W-1:0]); // RULE_04

  // turn-off on over-current outside blanking; turn-on on bottom or timeouts
  assign turn_off = (state == SEQ_ON) && s_oc && !blanked; // RULE_01
  assign turn_on  = (state == SEQ_OFF) && !masked &&
                    (s_bot // RULE_03
                     || (tout1_cnt >= TOUT1_CYCLES[CNT_W-1:0]) // RULE_05
                     || (bottom_seen && below_seen && tout2_cnt >= TOUT2_CYCLES[CNT_W-1:0])); // RULE_06 RULE_07

  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      SEQ_STOPPED: begin
        if (s_start && !protect) begin
          next_state = SEQ_OFF; // RULE_20
        end
      end
      SEQ_OFF: begin
        if (protect) begin
          next_state = SEQ_STOPPED;
        end else if (turn_on) begin
          next_state = SEQ_ON;
        end
      end
      SEQ_ON: begin
        if (protect) begin
          next_state = SEQ_STOPPED; // RULE_10
        end else if (turn_off) begin
          next_state = SEQ_OFF;
        end
      end
      default: next_state = SEQ_STOPPED;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= SEQ_STOPPED;
    end else begin
      state <= next_state;
    end
  end

  // gate output is registered off the next state
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gate_out <= 1'b0;
    end else begin
      gate_out <= (next_state == SEQ_ON);
    end
  end

  // blanking restarts on the gate rising, mask on either gate edge
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      blank_cnt <= '0;
      mask_cnt  <= '0;
    end else begin
      blank_cnt <= (state != SEQ_ON && next_state == SEQ_ON) ? '0 : bump(blank_cnt); // RULE_01
      mask_cnt  <= (state != next_state) ? '0 : bump(mask_cnt); // RULE_04
    end
  end

  // timeout 1 counts while sense stays under 200 mV during off time
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tout1_cnt <= '0;
    end else if (state != SEQ_OFF || s_abv) begin
      tout1_cnt <= '0; // RULE_05
    end else begin
      tout1_cnt <= bump(tout1_cnt);
    end
  end

  // timeout 2 counts from the sense falling below the timeout level
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tout2_cnt  <= '0;
      below_seen <= 1'b0;
    end else if (state != SEQ_OFF || s_abv) begin
      tout2_cnt  <= '0;
      below_seen <= 1'b0;
    end else begin
      below_seen <= 1'b1;
      tout2_cnt  <= bump(tout2_cnt); // RULE_06
    end
  end

  // arming flag for timeout 2; cleared whenever switching stops
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bottom_seen <= 1'b0;
    end else if (!running) begin
      bottom_seen <= 1'b0; // RULE_07
    end else if (state == SEQ_OFF && !masked && s_bot) begin
      bottom_seen <= 1'b1;
    end
  end

  // soft start clock; reset by undervoltage or brown-out
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ss_cnt <= '0;
    end else if (s_uv || !s_line) begin
      ss_cnt <= '0; // RULE_08
    end else if (running && !ss_done) begin
      ss_cnt <= bump(ss_cnt);
    end
  end
  assign ss_done = (ss_cnt >= SS2_CYCLES[CNT_W-1:0]);
  assign ss_pct  = (ss_cnt < SS1_CYCLES[CNT_W-1:0]) ? LIMIT_PCT_SS1 :
                   (!ss_done ? LIMIT_PCT_SS2 : LIMIT_PCT_NORMAL); // RULE_09

  // limit percentage, scaled by 0.7 at high line (70/100)
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      limit_pct_out <= LIMIT_PCT_SS1;
    end else if (s_hl) begin
      limit_pct_out <= 8'((16'(ss_pct) * 16'(HIGH_LINE_PCT)) / 16'h0064); // RULE_02
    end else begin
      limit_pct_out <= ss_pct;
    end
  end
  assign soft_start_out = !ss_done;

  // overload timer; any dip below lower level clears it
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ol_cnt <= '0;
    end else if (s_fbl) begin
      ol_cnt <= '0; // RULE_11
    end else if (s_fbu && running) begin
      ol_cnt <= bump(ol_cnt); // RULE_10
    end
  end
  assign ol_trip = (ol_cnt >= OVERLOAD_CYCLES[CNT_W-1:0]);

  // overvoltage filters: short episodes restart the count
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aovp_cnt <= '0;
      vovp_cnt <= '0;
    end else begin
      aovp_cnt <= s_aov ? bump(aovp_cnt) : '0; // RULE_13
      vovp_cnt <= s_vov ? bump(vovp_cnt) : '0;
    end
  end
  assign aovp_trip = (aovp_cnt >= OVP_CYCLES[CNT_W-1:0]);
  assign vovp_trip = (vovp_cnt >= OVP_CYCLES[CNT_W-1:0]);
  assign ovp_now   = aovp_trip | vovp_trip;

  // latches; release wins only when no trip stands in the same cycle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ol_latch  <= 1'b0;
      aov_latch <= 1'b0;
      vov_latch <= 1'b0;
    end else begin
      ol_latch  <= (OVERLOAD_LATCH && ol_trip) || (ol_latch && !s_rel); // RULE_12 RULE_19
      aov_latch <= aovp_trip || (aov_latch && !s_rel); // RULE_12 RULE_13
      vov_latch <= (SUPPLY_OVP_LATCH && vovp_trip) || (vov_latch && !s_rel); // RULE_19
    end
  end

  // auto-recovery supply overvoltage holds off while the condition lasts
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vov_auto <= 1'b0;
    end else begin
      vov_auto <= !SUPPLY_OVP_LATCH && (vovp_trip || (vov_auto && s_vov)); // RULE_19
    end
  end

  // status outputs
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      overload_out <= 1'b0;
      latched_out  <= 1'b0;
    end else begin
      overload_out <= ol_trip | ol_latch;
      latched_out  <= ol_latch | aov_latch | vov_latch;
    end
  end

  clamp_delay u_clamp (
    .clk_in          (clk_in),
    .resetn_in       (resetn_in),
    .gate_in         (gate_out),
    .soft_start_in   (soft_start_out),
    .clamp_oe_out    (clamp_oe_out),
    .clamp_drive_out (clamp_drive_out)
  );

  // blanking only shields over-current; a protection may still cut the gate
  AST_BLANK: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_01
    (state == SEQ_ON && blanked && !protect) |=> gate_out) else $error("gate cut inside blanking");
  AST_OVERLOAD_OFF: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_10
    ol_trip |=> !gate_out) else $error("gate on during overload");
  AST_FB_CLEAR: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_11
    s_fbl |=> ol_cnt == '0) else $error("overload timer not cleared");
  AST_OL_COUNT: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_10
    (s_fbu && !s_fbl && running && !ol_trip) |=> ol_cnt == $past(ol_cnt) + 24'h000001)
    else $error("overload timer not counting");
  AST_AOV_LATCH: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_13
    aovp_trip && !s_rel |=> aov_latch ##1 (aov_latch || $past(s_rel)))
    else $error("aux overvoltage latch missing");
  AST_OVP_FILTER: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_13
    !s_aov |=> aovp_cnt == '0) else $error("ovp filter not reset");
  AST_SS_RESET: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_08
    (s_uv || !s_line) |=> ss_cnt == '0 && !gate_out) else $error("soft start not reset");
  AST_SS_LIMIT: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_09
    (!s_hl && ss_cnt < SS1_CYCLES[CNT_W-1:0]) |=> limit_pct_out == LIMIT_PCT_SS1)
    else $error("soft start limit wrong");
  AST_HIGH_LINE: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_02
    (s_hl && ss_done) |=> limit_pct_out == HIGH_LINE_PCT) else $error("high line scale wrong");
  AST_TSD_STOP: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_17
    s_tsd |=> !gate_out) else $error("switching during thermal shutdown");
  AST_MASK: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_04
    $fell(gate_out) |=> !gate_out [*8]) else $error("turn-on inside mask");
  // turn-on paths: once the mask is over each one must switch the gate on; timeout 2 stays off before any bottom
  AST_BOTTOM_ON: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_03
    (state == SEQ_OFF && !masked && !protect && s_bot) |=> gate_out)
    else $error("bottom did not turn gate on");
  AST_TOUT1_ON: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_05
    (state == SEQ_OFF && !masked && !protect && tout1_cnt >= TOUT1_CYCLES[CNT_W-1:0]) |=> gate_out)
    else $error("first timeout did not force gate on");
  AST_TOUT2_ON: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_06
    (state == SEQ_OFF && !masked && !protect && bottom_seen && below_seen && tout2_cnt >= TOUT2_CYCLES[CNT_W-1:0])
    |=> gate_out) else $error("second timeout did not force gate on");
  AST_TOUT2_ARM: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_07
    (state == SEQ_OFF && !bottom_seen && !s_bot && tout1_cnt < TOUT1_CYCLES[CNT_W-1:0]) |=> !gate_out)
    else $error("second timeout acted before any bottom");
  // start, automatic restart, latch holding and supply overvoltage latch setting
  AST_START: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_20
    (state == SEQ_STOPPED && (!s_start || protect)) |=> (state == SEQ_STOPPED && !gate_out))
    else $error("switching started without start conditions");
  AST_RESTART: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_18
    (state == SEQ_STOPPED && s_start && !protect) |=> state == SEQ_OFF)
    else $error("no automatic restart");
  AST_LATCH_HOLD: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_12
    ((ol_latch || aov_latch || vov_latch) && !s_rel) |=> latched_out)
    else $error("latch dropped without release");
  AST_VOV_LATCH: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE_19
    (SUPPLY_OVP_LATCH && vovp_trip) |=> vov_latch) else $error("supply overvoltage latch missing");
endmodule : qr_switch_timing

//--- verification/flyback_model.sv
/*
  Behavioural model of the power switch, current sense and auxiliary
  winding seen by the timing sequencer. Assumes gate_in is registered on
  clk_in; outputs change one small delay after each rising edge.
*/
`timescale 1ns/1ps
module flyback_model (
  input  wire logic       clk_in,
  input  wire logic       gate_in,
  input  wire logic [1:0] ring_mode_in,
  output logic            overcurrent_out,
  output logic            bottom_detect_out,
  output logic            above_level_out
);
  // ring_mode_in: 0 aux pin shorted, 1 normal valleys, 2 valley never reached
  localparam int ON_CYC    = 40;
  localparam int DEMAG_CYC = 60;
  int   cnt   = 0;
  logic gate_q = 1'h0;

  initial begin
    overcurrent_out   = 1'h0;
    bottom_detect_out = 1'h0;
    above_level_out   = 1'h0;
  end

  // cycles since the last gate edge drive every waveform
  always @(posedge clk_in) begin
    #1;
    cnt = (gate_in != gate_q) ? 0 : cnt + 1;
    gate_q = gate_in;
    // switch-on surge for 3 cycles, then the ramp crossing the limit
    overcurrent_out = gate_in && (cnt < 3 || cnt >= ON_CYC);
    // demagnetising plateau keeps the sense above the timeout level
    above_level_out = !gate_in && ring_mode_in != 2'h0 && cnt < DEMAG_CYC;
    // ringing noise just after each edge, then the valley itself
    bottom_detect_out = (ring_mode_in != 2'h0 && cnt < 4) || (!gate_in && ring_mode_in == 2'h1 && cnt >= DEMAG_CYC);
  end
endmodule : flyback_model

//--- verification/tb.sv
/*
  Self-checking bench for the quasi-resonant timing sequencer.
  Assumes the flyback model on the gate and a 50 MHz clock; long counts
  other than the overvoltage filter are shortened through the design parameters.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; $display("Error %s expected %0d seen %0d", n, e, g); end end
module tb
  import qr_timing_pkg::*;
();
  logic       clk_in          = 1'h0;
  logic       resetn_in       = 1'h0;
  logic       high_line_in    = 1'h0;
  logic       fb_above        = 1'h0;
  logic       fb_below        = 1'h0;
  logic       line_normal     = 1'h0;
  logic       supply_start    = 1'h0;
  logic       supply_uv       = 1'h0;
  logic       latch_release   = 1'h0;
  logic       supply_ov       = 1'h0;
  logic       aux_ov          = 1'h0;
  logic       thermal         = 1'h0;
  logic [1:0] ring_mode       = 2'h0;
  logic       overcurrent;
  logic       bottom_detect;
  logic       above_level;
  logic       gate_out;
  logic [7:0] limit_pct_out;
  logic       soft_start_out;
  logic       overload_out;
  logic       latched_out;
  logic       clamp_oe_out;
  logic       clamp_drive_out;
  int         bad_count       = 0;
  int         total_checks    = 0;
  // open-drain pin with its external pull-up
  wire        clamp_pin       = clamp_oe_out ? clamp_drive_out : 1'h1;

  qr_switch_timing #(.OVERLOAD_CYCLES(200), .SS1_CYCLES(100), .SS2_CYCLES(400),
    .TOUT1_CYCLES(40), .TOUT2_CYCLES(20)) i_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .overcurrent_in(overcurrent), .high_line_in(high_line_in),
    .bottom_detect_in(bottom_detect), .above_timeout_level_in(above_level), .fb_above_upper_in(fb_above),
    .fb_below_lower_in(fb_below), .line_normal_in(line_normal), .supply_start_in(supply_start),
    .supply_undervoltage_in(supply_uv), .supply_latch_release_in(latch_release),
    .supply_overvoltage_in(supply_ov), .aux_overvoltage_in(aux_ov), .thermal_shutdown_in(thermal),
    .gate_out(gate_out), .limit_pct_out(limit_pct_out), .soft_start_out(soft_start_out),
    .overload_out(overload_out), .latched_out(latched_out), .clamp_oe_out(clamp_oe_out),
    .clamp_drive_out(clamp_drive_out));

  flyback_model i_model (.clk_in(clk_in), .gate_in(gate_out), .ring_mode_in(ring_mode),
    .overcurrent_out(overcurrent), .bottom_detect_out(bottom_detect), .above_level_out(above_level));

  initial begin
    forever #10 clk_in = ~clk_in;
  end

  task automatic report_and_stop();
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // every input change lands 1 ns after a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc

  task automatic wait_gate(input logic v, input int lim, output int n);
    n = 0;
    while (gate_out !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wait_gate

  task automatic in_range(input string what, input int n, input int lo, input int hi);
    total_checks++;
    if (n < lo || n > hi) begin
      bad_count++;
      $display("Error %s expected %0d to %0d seen %0d", what, lo, hi, n);
    end
  endtask : in_range

  task automatic gate_quiet(input int n);
    int hits;
    hits = 0;
    repeat (n) begin
      cyc(1);
      hits += (gate_out !== 1'h0);
    end
    `CHK("gate quiet", 0, hits)
  endtask : gate_quiet

  // one switching period measured from a clean falling edge
  task automatic period(input int off_lo, input int off_hi);
    int n;
    wait_gate(1'h1, 300, n);
    wait_gate(1'h0, 300, n);
    wait_gate(1'h1, 300, n);
    in_range("off time", n, off_lo, off_hi);
    cyc(10);
    `CHK("clamp after rise", 1'h0, clamp_pin)
    cyc(25);
    `CHK("clamp copy of gate", 1'h1, clamp_pin)
    wait_gate(1'h0, 300, n);
    in_range("on time", n + 35, 40, 48);
  endtask : period

  // brown-out (line) or supply undervoltage outage and recovery
  task automatic outage(input logic line);
    int n;
    line_normal = !line;
    supply_uv = !line;
    supply_start = line;
    cyc(6);
    `CHK("soft start rerun", 1'h1, soft_start_out)
    gate_quiet(20);
    line_normal = 1'h1;
    supply_uv = 1'h0;
    supply_start = 1'h1;
    wait_gate(1'h1, 300, n);
    in_range("auto restart", n, 0, 299);
    `CHK("limit after restart", LIMIT_PCT_SS1, limit_pct_out)
  endtask : outage

  task automatic trip_latch(input logic aux);
    int n;
    aux_ov = aux;
    supply_ov = !aux;
    cyc(OVP_FILTER_CYC + 20);
    aux_ov = 1'h0;
    supply_ov = 1'h0;
    gate_quiet(30);
    `CHK("latch held", 1'h1, latched_out)
    latch_release = 1'h1;
    cyc(6);
    latch_release = 1'h0;
    `CHK("latch released", 1'h0, latched_out)
    wait_gate(1'h1, 300, n);
    in_range("latch restart", n, 0, 299);
  endtask : trip_latch

  // soft start leaves the clamp released even while the gate is high
  always @(negedge clk_in) begin
    if (soft_start_out === 1'h1 && gate_out === 1'h1)
      `CHK("clamp released in soft start", 1'h0, clamp_oe_out)
  end

  initial begin
    #900_000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    int n;
    cyc(3);
    `CHK("gate in reset", 1'h0, gate_out)
    `CHK("limit in reset", LIMIT_PCT_SS1, limit_pct_out)
    `CHK("overload in reset", 1'h0, overload_out)
    cyc(3);
    resetn_in = 1'h1;
    cyc(2);
    `CHK("clamp after reset", 1'h1, clamp_pin)
    gate_quiet(20);
    // start with the aux pin shorted: only the first timeout can fire
    supply_start = 1'h1;
    line_normal = 1'h1;
    wait_gate(1'h1, 300, n);
    in_range("first start", n, 40, 52);
    `CHK("limit stage one", LIMIT_PCT_SS1, limit_pct_out)
    n = 0;
    while (limit_pct_out !== LIMIT_PCT_SS2 && n < 1000) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (soft_start_out !== 1'h0 && n < 1000) begin
      cyc(1);
      n++;
    end
    in_range("stage two length", n, 297, 303);
    cyc(2);
    `CHK("limit normal", LIMIT_PCT_NORMAL, limit_pct_out)
    period(38, 48);
    // valleys present: noise masked, valley turns the gate on
    ring_mode = 2'h1;
    period(60, 68);
    high_line_in = 1'h1;
    cyc(6);
    `CHK("high line limit", HIGH_LINE_PCT, limit_pct_out)
    high_line_in = 1'h0;
    cyc(6);
    ring_mode = 2'h2;
    period(78, 88);
    ring_mode = 2'h1;
    // overload timer cleared by one dip, then a full trip
    fb_above = 1'h1;
    cyc(150);
    fb_above = 1'h0;
    fb_below = 1'h1;
    cyc(3);
    fb_below = 1'h0;
    fb_above = 1'h1;
    cyc(150);
    `CHK("overload after dip", 1'h0, overload_out)
    cyc(70);
    `CHK("overload tripped", 1'h1, overload_out)
    gate_quiet(40);
    fb_above = 1'h0;
    fb_below = 1'h1;
    cyc(10);
    fb_below = 1'h0;
    `CHK("overload auto clear", 1'h0, overload_out)
    wait_gate(1'h1, 300, n);
    in_range("overload restart", n, 0, 299);
    // two short aux overvoltage episodes: each must restart the filter
    repeat (2) begin
      aux_ov = 1'h1;
      cyc(OVP_FILTER_CYC - 20);
      aux_ov = 1'h0;
      cyc(10);
    end
    `CHK("short episode", 1'h0, latched_out)
    trip_latch(1'h1);
    trip_latch(1'h0);
    thermal = 1'h1;
    cyc(6);
    gate_quiet(100);
    thermal = 1'h0;
    wait_gate(1'h1, 300, n);
    in_range("thermal resume", n, 0, 299);
    `CHK("no latch on thermal", 1'h0, latched_out)
    outage(1'h1);
    outage(1'h0);
    report_and_stop();
  end
endmodule : tb
